// *** design/opamp_ctl_pkg.sv ***
/*
 package for the second amplifier control register: offsets, field positions,
 reset value, decode types. assumes a 32-bit apb slave with word-aligned registers.
*/
package opamp_ctl_pkg;
   // printed offset f97 is not a multiple of four: it is kept as an index
   localparam logic [11:0] ctl_one_index     = 12'hf97;
   localparam logic [13:0] ctl_one_addr      = {ctl_one_index, 2'b00};
   localparam logic [7:0]  ctl_one_reset     = 8'h00;
   localparam logic [7:0]  ctl_one_wr_mask   = 8'h3b;
   localparam int          mode_pos          = 0;
   localparam int          neg_sel_pos       = 1;
   localparam int          power_pos         = 3;
   localparam int          res_sel_lo        = 4;
   localparam int          res_sel_hi        = 5;

   typedef enum logic [2:0] {
      neg_pin      = 3'b000,
      neg_feedback = 3'b001,
      neg_res_ext  = 3'b100,
      neg_res_10u  = 3'b101,
      neg_res_100u = 3'b110,
      neg_res_1m   = 3'b111
   } neg_route_t;

   typedef struct packed {
      logic       current_mode;
      neg_route_t neg_route;
      logic       amplifier_power_select;
   } amp_b_ctl_t;
endpackage

// *** design/apb_word_slave.sv ***
/*
 apb slave front end for a single word register: address decode, zero-wait
 answer, error on unmapped address. assumes the standard apb master handshake.
*/
`timescale 1ns/1ns
`default_nettype none
module apb_word_slave
   import opamp_ctl_pkg::*;
(
   // apb
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [15:0] paddr,
   output logic             pready,
   output logic             pslverr,
   // register side
   output logic             hit,
   output logic             wr_en
);
   wire access = psel & penable;
   // the byte address is four times the index, so the word bits are the index
   assign hit     = (paddr[15:2] == {2'b00, ctl_one_index});
   assign pready  = access;
   assign pslverr = access & ~hit;
   assign wr_en   = access & pwrite & hit;
endmodule
`default_nettype wire

// *** design/amp_b_decode.sv ***
/*
 decodes the stored control byte into amplifier select lines.
 assumes the analogue side samples these levels at will.
*/
`timescale 1ns/1ns
`default_nettype none
module amp_b_decode
   import opamp_ctl_pkg::*;
(
   // register value
   input  wire logic [7:0] ctl,
   input  wire logic       amp_a_power,
   // decoded
   output amp_b_ctl_t      sel
);
   function automatic neg_route_t route(input logic [7:0] c);
      if (c[mode_pos]) begin
         // RQ5
         route = neg_route_t'({1'b1, c[res_sel_hi:res_sel_lo]});
      end else begin
         // RQ8
         route = c[neg_sel_pos] ? neg_feedback : neg_pin;
      end
   endfunction
   assign sel.current_mode           = ctl[mode_pos]; // RQ9
   assign sel.neg_route              = route(ctl); // RQ4
   assign sel.amplifier_power_select = ctl[power_pos] | amp_a_power; // RQ6 RQ7
endmodule
`default_nettype wire

// *** design/op_amp_b_control.sv ***
/*
 top: second amplifier control register behind apb, with decoded outputs.
 assumes pclk at 25 MHz and that the first amplifier supplies its power bit.
*/
// What this block does
// RQ1: 8-bit register at index f97, resets zero
// RQ2: bits 7:6 read-only reserved, write 00
// RQ3: bit 2 read-only reserved, write 0
// RQ4: bits 5:4 choose external or internal resistor
// RQ5: resistor select only acts in current mode
// RQ6: bit 3 selects low or normal power
// RQ7: power line is or of both amplifiers
// RQ8: bit 1 chooses pin or feedback input
// RQ9: bit 0 selects normal or current mode
// RQ10: reserved bits ignore writes, read zero
`timescale 1ns/1ns
`default_nettype none
module op_amp_b_control
   import opamp_ctl_pkg::*;
(
   // clock and reset
   input  wire logic        pclk,
   input  wire logic        presetn,
   // apb
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [15:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   // amplifier side
   input  wire logic        amp_a_power,
   output amp_b_ctl_t       amp_b_sel
);
   logic [7:0]  op_amp_b_control_one_q;
   logic [7:0]  op_amp_b_control_one_d;
   logic [31:0] prdata_q;
   logic [31:0] prdata_d;
   logic        hit;
   logic        wr_en;

   apb_word_slave u_bus (
      .psel    (psel),
      .penable (penable),
      .pwrite  (pwrite),
      .paddr   (paddr),
      .pready  (pready),
      .pslverr (pslverr),
      .hit     (hit),
      .wr_en   (wr_en)
   );

   // reserved bits are masked off so they never store a one
   assign op_amp_b_control_one_d = wr_en ? (pwdata[7:0] & ctl_one_wr_mask)
                                         : op_amp_b_control_one_q; // RQ10 RQ2 RQ3
   // read data registered in setup so it is stable in the access phase
   assign prdata_d = (psel & ~penable & ~pwrite & hit)
                     ? {24'h000000, op_amp_b_control_one_q} : 32'h00000000;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         op_amp_b_control_one_q <= ctl_one_reset; // RQ1
         prdata_q               <= 32'h00000000;
      end else begin
         op_amp_b_control_one_q <= op_amp_b_control_one_d;
         prdata_q               <= prdata_d;
      end
   end
   assign prdata = prdata_q;

   amp_b_decode u_dec (
      .ctl         (op_amp_b_control_one_q),
      .amp_a_power (amp_a_power),
      .sel         (amp_b_sel)
   );

   chk_reserved_zero: assert property (@(posedge pclk) disable iff (!presetn)
      (op_amp_b_control_one_q & ~ctl_one_wr_mask) == 8'h00) // RQ10
      else $error("reserved bit set");
   chk_upper_reserved: assert property (@(posedge pclk) disable iff (!presetn)
      op_amp_b_control_one_q[7:6] == 2'b00) // RQ2
      else $error("bits 7:6 not zero");
   chk_bit_two: assert property (@(posedge pclk) disable iff (!presetn)
      !op_amp_b_control_one_q[2]) // RQ3
      else $error("bit 2 not zero");
   chk_write_lands: assert property (@(posedge pclk) disable iff (!presetn)
      wr_en |=> op_amp_b_control_one_q == ($past(pwdata[7:0]) & ctl_one_wr_mask)) // RQ1
      else $error("write not stored");
   chk_power_or: assert property (@(posedge pclk) disable iff (!presetn)
      amp_b_sel.amplifier_power_select ==
      (op_amp_b_control_one_q[power_pos] | amp_a_power)) // RQ7
      else $error("power or wrong");
   chk_power_bit: assert property (@(posedge pclk) disable iff (!presetn)
      (wr_en && pwdata[power_pos]) |=> amp_b_sel.amplifier_power_select) // RQ6
      else $error("power bit ignored");
   chk_res_route: assert property (@(posedge pclk) disable iff (!presetn)
      op_amp_b_control_one_q[mode_pos] |->
      amp_b_sel.neg_route[1:0] == op_amp_b_control_one_q[5:4]
      && amp_b_sel.neg_route[2]) // RQ4
      else $error("resistor route wrong");
   chk_normal_route: assert property (@(posedge pclk) disable iff (!presetn)
      !op_amp_b_control_one_q[mode_pos] |->
      amp_b_sel.neg_route[2:1] == 2'b00
      && amp_b_sel.neg_route[0] == op_amp_b_control_one_q[neg_sel_pos]) // RQ8
      else $error("normal route wrong");
   chk_mode_out: assert property (@(posedge pclk) disable iff (!presetn)
      amp_b_sel.current_mode == op_amp_b_control_one_q[mode_pos]) // RQ9
      else $error("mode output wrong");
   chk_mode_ignore: assert property (@(posedge pclk) disable iff (!presetn)
      (amp_b_sel.current_mode && $stable(op_amp_b_control_one_q[5:4]))
      |-> $stable(amp_b_sel.neg_route) || $changed(op_amp_b_control_one_q[0])) // RQ5
      else $error("route moved in current mode");
   chk_read_back: assert property (@(posedge pclk) disable iff (!presetn)
      (psel && !penable && !pwrite && hit) |=>
      prdata[7:0] == $past(op_amp_b_control_one_q) && prdata[31:8] == 24'h000000) // RQ10
      else $error("read data wrong");

   cov_write: cover property (@(posedge pclk) disable iff (!presetn) wr_en);
   cov_current: cover property (@(posedge pclk) disable iff (!presetn)
      amp_b_sel.neg_route == neg_res_1m);
   cov_feedback: cover property (@(posedge pclk) disable iff (!presetn)
      amp_b_sel.neg_route == neg_feedback);
   cov_unmapped: cover property (@(posedge pclk) disable iff (!presetn) pslverr);
endmodule
`default_nettype wire

// *** tb/op_amp_b_control_tb.sv ***
/*
 self-checking bench for the second amplifier control register.
 assumes a 25 MHz pclk and an apb slave that may add wait states.
*/
`timescale 1ns/1ns
`default_nettype none
module op_amp_b_control_tb
   import opamp_ctl_pkg::*;
;
   localparam logic [15:0] reg_addr = {2'b00, ctl_one_addr};
   logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
   logic        amp_a_power = 0, pready, pslverr, err;
   logic [15:0] paddr = '0;
   logic [31:0] pwdata = '0, prdata, rd;
   amp_b_ctl_t  amp_b_sel;
   int          failures = 0, checks = 0;

   op_amp_b_control u_op_amp_b_control (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .amp_a_power(amp_a_power), .amp_b_sel(amp_b_sel));

   always #20 pclk = ~pclk;

   task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
      checks++;
      if (got !== exp) begin
         failures++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask

   // one apb transfer; read data and response taken at the pready edge
   task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   // write, read back, then check the stored byte and the decoded lines
   task automatic wrchk(input logic [7:0] d, input logic [4:0] exp_sel);
      apb(1'b1, reg_addr, {24'h0, d});
      apb(1'b0, reg_addr, 32'h0);
      cmp("readback", {24'h0, d & 8'h3b}, rd);
      cmp("select", {27'h0, exp_sel}, {27'h0, amp_b_sel});
   endtask

   task automatic t_reset;
      apb(1'b0, reg_addr, 32'h0);
      cmp("reset value", 32'h0, rd);
      cmp("reset select", 32'h0, {27'h0, amp_b_sel});
      $display("reset test done");
   endtask

   task automatic t_reserved;
      wrchk(8'hff, 5'h1f);
      wrchk(8'hc4, 5'h00);
      $display("reserved test done");
   endtask

   task automatic t_current;
      for (int i = 0; i < 4; i++) wrchk({2'b0, i[1:0], 4'h3}, {2'b11, i[1:0], 1'b0});
      $display("current mode test done");
   endtask

   task automatic t_normal;
      for (int i = 0; i < 8; i++) wrchk({2'b0, i[2:1], 2'b0, i[0], 1'b0}, {3'b0, i[0], 1'b0});
      $display("normal mode test done");
   endtask

   task automatic t_power;
      for (int i = 0; i < 4; i++) begin
         @(posedge pclk) amp_a_power <= i[1];
         wrchk({4'h0, i[0], 3'h0}, {4'h0, i[1] | i[0]});
      end
      $display("power test done");
   endtask

   task automatic t_unmapped;
      // the power test leaves the first amplifier's bit set
      @(posedge pclk) amp_a_power <= 1'b0;
      wrchk(8'h01, 5'h18);
      apb(1'b1, reg_addr + 16'h4, 32'h0);
      cmp("unmapped write error", 32'h1, {31'h0, err});
      apb(1'b0, reg_addr + 16'h4, 32'h0);
      cmp("unmapped read data", 32'h0, rd);
      apb(1'b0, reg_addr, 32'h0);
      cmp("register kept", 32'h1, rd);
      $display("unmapped test done");
   endtask

   task automatic stop_test;
      $display("checks %0d failures %0d", checks, failures);
      if (failures == 0 && checks > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask

   // whole run needs well under 600 cycles
   initial begin
      repeat (3000) @(posedge pclk);
      failures++;
      stop_test();
   end

   initial begin
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      t_reset();
      t_reserved();
      t_current();
      t_normal();
      t_power();
      t_unmapped();
      stop_test();
   end
endmodule
`default_nettype wire
